// *** eeprom_map.svh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// ----------------------------------------------------------------------
// Register byte addresses on the register bus
// ----------------------------------------------------------------------
`define EE_OFS_MCR      16'h00F0
`define EE_OFS_BPROT    16'h00F4
`define EE_OFS_TEST     16'h00F8
`define EE_OFS_PROG     16'h00FC
`define EE_OFS_INIT     16'h0100

// ----------------------------------------------------------------------
// Array window on the memory bus
// ----------------------------------------------------------------------
`define EE_ARR_FIRST    16'h0D00
`define EE_ARR_LAST     16'h0FFF
`define EE_ARR_BYTES    768
`define EE_ARR_END      10'h300
`define EE_ERASED       8'hFF

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define EE_MCR_WCS      2
`define EE_MCR_LOCK     1
`define EE_MCR_PSEL     0
`define EE_MCR_ONES     8'hF8
`define EE_MCR_RESET    8'hFC
`define EE_PROG_BULK_ERASE_PROTECTION   7
`define EE_PROG_BYTE    4
`define EE_PROG_ROW     3
`define EE_PROG_ERASE   2
`define EE_PROG_LATCH   1
`define EE_PROG_PGM     0
`define EE_PROG_RESET   8'h80
`define EE_BPROT_RESET  5'h1F
`define EE_TEST_ODD     1
`define EE_TEST_EVEN    0
`define EE_INIT_RDEN    0
`define EE_INIT_DONE    7
`define EE_RESP_OKAY    2'h0
`define EE_RESP_SLVERR  2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define EE_CLK_NS       5
`define EE_TICK_NS      1000
`define EE_TICK_CYCLES  ((`EE_TICK_NS + `EE_CLK_NS - 1) / `EE_CLK_NS)
`define EE_RC_CYCLES    40
`define EE_PROG_TICKS   10

`endif

// *** eeprom_types_pkg.sv ***
// Types shared by the array control block.
package eeprom_types_pkg;

	typedef enum logic {RD_IDLE, RD_SECOND} rd_state_type;

	typedef logic [9:0] array_index_type;

	typedef logic [7:0] data_byte_type;

endpackage

// *** eeprom_pump_timer.sv ***
// Charge-pump clock divider and program/erase duration counter.
`timescale 1ns/1ps
`include "eeprom_map.svh"

module eeprom_pump_timer #(
	parameter int SYS_DIV = `EE_TICK_CYCLES,
	parameter int RC_DIV  = `EE_RC_CYCLES,
	parameter int TICKS   = `EE_PROG_TICKS
)(
	input  wire logic i_core_clk,
	input  wire logic i_srst,
	input  wire logic i_run,
	input  wire logic i_clear,
	input  wire logic i_rc_sel,
	output logic      o_done
);
	import eeprom_types_pkg::*;

	logic [15:0] div_q;
	logic [15:0] cnt_q;
	logic [15:0] lim;
	logic        tick;

	// The pump runs from the RC oscillator or from the system clock.
	assign lim  = i_rc_sel ? 16'(RC_DIV - 1) : 16'(SYS_DIV - 1);
	assign tick = i_run && (div_q >= lim);

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			div_q <= 16'h0000;
		else if (i_run)
			div_q <= tick ? 16'h0000 : div_q + 16'h0001;
	end

	// The count holds while paused so that a stop or wait resumes it.
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst || i_clear)
			cnt_q <= 16'h0000;
		else if (tick && cnt_q != 16'(TICKS))
			cnt_q <= cnt_q + 16'h0001;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst || i_clear)
			o_done <= 1'b0;
		else
			o_done <= tick && cnt_q == 16'(TICKS - 1);
	end

endmodule // eeprom_pump_timer

// *** eeprom_array_control.sv ***
// Control of the electrically erasable array and its register block.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "eeprom_map.svh"

module eeprom_array_control #(
	parameter int SYS_DIV = `EE_TICK_CYCLES,
	parameter int RC_DIV  = `EE_RC_CYCLES,
	parameter int TICKS   = `EE_PROG_TICKS
)(
	input  wire logic                           i_core_clk,
	input  wire logic                           i_srst,
	input  wire logic [15:0]                    i_awaddr,
	input  wire logic                           i_awvalid,
	output logic                                o_awready,
	input  wire logic [31:0]                    i_wdata,
	input  wire logic [3:0]                     i_wstrb,
	input  wire logic                           i_wvalid,
	output logic                                o_wready,
	output logic [1:0]                          o_bresp,
	output logic                                o_bvalid,
	input  wire logic                           i_bready,
	input  wire logic [15:0]                    i_araddr,
	input  wire logic                           i_arvalid,
	output logic                                o_arready,
	output logic [31:0]                         o_rdata,
	output logic [1:0]                          o_rresp,
	output logic                                o_rvalid,
	input  wire logic                           i_rready,
	input  wire logic [15:0]                    i_mem_addr,
	input  wire logic                           i_mem_rd,
	input  wire logic                           i_mem_wr,
	input  wire logic                           i_mem_word,
	input  wire logic [15:0]                    i_mem_wdata,
	output logic                                o_mem_ack,
	output logic [15:0]                         o_mem_rdata,
	input  wire logic                           i_special_mode_flag,
	input  wire logic                           i_wait_mode,
	input  wire logic                           i_stop_mode,
	output logic                                o_pump_voltage_on,
	output logic                                o_rc_osc_run,
	output logic                                o_module_clk_en
);
	import eeprom_types_pkg::*;

	// ------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------
	function automatic logic in_array(input logic [15:0] a);
		return a >= `EE_ARR_FIRST && a <= `EE_ARR_LAST;
	endfunction

	// Block boundaries: 256, 256, 128, 64 and 64 bytes.
	function automatic logic is_protected(input array_index_type i,
		input logic [4:0] bp);
		if (i < 10'h100)
			return bp[4];
		if (i < 10'h200)
			return bp[3];
		if (i < 10'h280)
			return bp[2];
		if (i < 10'h2C0)
			return bp[1];
		return bp[0];
	endfunction

	// Row parity is the physical row, bit 5 of the array index.
	function automatic logic erase_hit(input array_index_type i,
		input array_index_type a, input logic w, input logic byt,
		input logic row, input logic odd, input logic even);
		if (odd || even)
			return (odd && i[5]) || (even && !i[5]);
		if (byt)
			return i == a || (w && i == (a | 10'h001));
		if (row)
			return i[9:5] == a[9:5];
		return 1'b1;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	data_byte_type   mem_q [`EE_ARR_BYTES];
	logic            wcs_q, lock_q, psel_q, lock_written_q;
	logic [4:0]      bprot_q;
	logic            odd_q, even_q;
	logic            bulk_erase_protection_q, byte_q, row_q, erase_q, latch_q, pgm_q;
	logic            read_en_q, op_done_q;
	logic [15:0]     aw_addr_q;
	logic [7:0]      wd_q;
	logic            wlane_q;
	array_index_type lat_addr_q;
	logic [15:0]     lat_data_q;
	logic            lat_word_q, lat_valid_q;
	rd_state_type    rd_state_q;
	array_index_type rd_next_q;
	data_byte_type   rd_hi_q;
	logic            wr_do, commit, clk_en, run;
	logic            bulk_class;
	array_index_type mem_ofs;
	logic [31:0]     rd_val;
	logic            rd_ok;

	assign mem_ofs = array_index_type'(i_mem_addr - `EE_ARR_FIRST);
	assign clk_en  = !(i_wait_mode && wcs_q);
	assign run     = pgm_q && !i_stop_mode && clk_en;
	assign bulk_class = odd_q || even_q || !byte_q;

	// ------------------------------------------------------------------
	// Register bus slave
	// ------------------------------------------------------------------
	// A write is done once address and data are both held.
	assign wr_do = !o_awready && !o_wready && !o_bvalid;

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			o_awready <= 1'b1;
			o_wready  <= 1'b1;
			o_bvalid  <= 1'b0;
			o_bresp   <= `EE_RESP_OKAY;
			aw_addr_q <= 16'h0000;
			wd_q      <= 8'h00;
			wlane_q   <= 1'b0;
		end
		else
		begin
			if (o_awready && i_awvalid)
			begin
				o_awready <= 1'b0;
				aw_addr_q <= i_awaddr;
			end
			if (o_wready && i_wvalid)
			begin
				o_wready <= 1'b0;
				wd_q     <= i_wdata[7:0];
				wlane_q  <= i_wstrb[0];
			end
			if (wr_do)
			begin
				o_bvalid <= 1'b1;
				o_bresp  <= rd_ok_w(aw_addr_q) ? `EE_RESP_OKAY
					: `EE_RESP_SLVERR;
			end
			if (o_bvalid && i_bready)
			begin
				o_bvalid  <= 1'b0;
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
		end
	end

	function automatic logic rd_ok_w(input logic [15:0] a);
		return a == `EE_OFS_MCR || a == `EE_OFS_BPROT ||
			a == `EE_OFS_TEST || a == `EE_OFS_PROG || a == `EE_OFS_INIT;
	endfunction

	// Registers answer whatever the read enable holds.
	always_comb
	begin
		rd_ok  = rd_ok_w(i_araddr);
		rd_val = 32'h0000_0000;
		case (i_araddr)
			`EE_OFS_MCR:
				rd_val[7:0] = `EE_MCR_ONES | {5'h00, wcs_q, lock_q, psel_q};
			`EE_OFS_BPROT:
				rd_val[4:0] = bprot_q;
			`EE_OFS_TEST:
				rd_val[1:0] = {odd_q, even_q};
			`EE_OFS_PROG:
				rd_val[7:0] = {bulk_erase_protection_q, 2'b00, byte_q, row_q, erase_q,
					latch_q, pgm_q};
			`EE_OFS_INIT:
				rd_val[7:0] = {op_done_q, 6'h00, read_en_q};
			default:
				rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= `EE_RESP_OKAY;
		end
		else if (o_arready && i_arvalid)
		begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b1;
			o_rdata   <= rd_val;
			o_rresp   <= rd_ok ? `EE_RESP_OKAY : `EE_RESP_SLVERR;
		end
		else if (o_rvalid && i_rready)
		begin
			o_rvalid  <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Module configuration
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			wcs_q          <= 1'(`EE_MCR_RESET >> `EE_MCR_WCS);
			lock_q         <= 1'b0;
			psel_q         <= 1'b0;
			lock_written_q <= 1'b0;
		end
		else if (wr_do && wlane_q && aw_addr_q == `EE_OFS_MCR)
		begin
			wcs_q          <= wd_q[`EE_MCR_WCS];
			psel_q         <= wd_q[`EE_MCR_PSEL];
			lock_written_q <= 1'b1;
			if (!i_special_mode_flag || !lock_written_q)
				lock_q <= wd_q[`EE_MCR_LOCK];
		end
	end

	// ------------------------------------------------------------------
	// Protection, test and program control
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			bprot_q <= `EE_BPROT_RESET;
		else if (wr_do && wlane_q && aw_addr_q == `EE_OFS_BPROT &&
			!pgm_q && !lock_q)
			bprot_q <= wd_q[4:0];
	end

	// Test bits are forced clear outside special modes.
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst || i_special_mode_flag)
		begin
			odd_q  <= 1'b0;
			even_q <= 1'b0;
		end
		else if (wr_do && wlane_q && aw_addr_q == `EE_OFS_TEST && !pgm_q)
		begin
			odd_q  <= wd_q[`EE_TEST_ODD];
			even_q <= wd_q[`EE_TEST_EVEN];
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			bulk_erase_protection_q <= 1'(`EE_PROG_RESET >> `EE_PROG_BULK_ERASE_PROTECTION);
			byte_q  <= 1'b0;
			row_q   <= 1'b0;
			erase_q <= 1'b0;
			latch_q <= 1'b0;
			pgm_q   <= 1'b0;
		end
		else if (wr_do && wlane_q && aw_addr_q == `EE_OFS_PROG)
		begin
			if (!pgm_q && !lock_q)
				bulk_erase_protection_q <= wd_q[`EE_PROG_BULK_ERASE_PROTECTION];
			if (!pgm_q)
			begin
				byte_q  <= wd_q[`EE_PROG_BYTE];
				row_q   <= wd_q[`EE_PROG_ROW];
				erase_q <= wd_q[`EE_PROG_ERASE];
			end
			// One write may clear both the voltage and the latch.
			if (!pgm_q || !wd_q[`EE_PROG_PGM])
				latch_q <= wd_q[`EE_PROG_LATCH];
			pgm_q <= wd_q[`EE_PROG_PGM] && latch_q;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			read_en_q <= 1'b1;
		else if (wr_do && wlane_q && aw_addr_q == `EE_OFS_INIT)
			read_en_q <= wd_q[`EE_INIT_RDEN];
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
			op_done_q <= 1'b0;
		else if (commit)
			op_done_q <= 1'b1;
		else if (!pgm_q)
			op_done_q <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Address and data latches
	// ------------------------------------------------------------------
	// Writes are taken in any mode and whatever the read enable holds.
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst || !latch_q)
		begin
			lat_addr_q  <= 10'h000;
			lat_data_q  <= 16'h0000;
			lat_word_q  <= 1'b0;
			lat_valid_q <= 1'b0;
		end
		else if (i_mem_wr && in_array(i_mem_addr) && !pgm_q)
		begin
			lat_addr_q  <= mem_ofs;
			lat_valid_q <= 1'b1;
			// A misaligned word degrades to its lower byte.
			lat_word_q  <= i_mem_word && !mem_ofs[0];
			lat_data_q  <= (i_mem_word && mem_ofs[0]) ?
				{i_mem_wdata[7:0], i_mem_wdata[7:0]} : i_mem_wdata;
		end
	end

	// ------------------------------------------------------------------
	// Pump timing and the array itself
	// ------------------------------------------------------------------
	eeprom_pump_timer #(
		.SYS_DIV (SYS_DIV),
		.RC_DIV  (RC_DIV),
		.TICKS   (TICKS)
	) u_timer (
		.i_core_clk (i_core_clk),
		.i_srst     (i_srst),
		.i_run      (run),
		.i_clear    (!pgm_q),
		.i_rc_sel   (psel_q),
		.o_done     (commit)
	);

	// The array is held erased after reset so reads are defined.
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			for (int i = 0; i < `EE_ARR_BYTES; i++)
				mem_q[i] <= `EE_ERASED;
		end
		else if (commit && lat_valid_q)
		begin
			for (int i = 0; i < `EE_ARR_BYTES; i++)
			begin
				if (!is_protected(10'(i), bprot_q))
				begin
					if (erase_q)
					begin
						if (erase_hit(10'(i), lat_addr_q, lat_word_q,
							byte_q, row_q, odd_q, even_q) &&
							!(bulk_class && bulk_erase_protection_q))
							mem_q[i] <= `EE_ERASED;
					end
					else if (10'(i) == lat_addr_q)
						mem_q[i] <= lat_word_q ? lat_data_q[15:8]
							: lat_data_q[7:0];
					else if (lat_word_q && 10'(i) == (lat_addr_q | 10'h001))
						mem_q[i] <= lat_data_q[7:0];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Array read port
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			rd_state_q  <= RD_IDLE;
			o_mem_ack   <= 1'b0;
			o_mem_rdata <= 16'h0000;
			rd_next_q   <= 10'h000;
			rd_hi_q     <= 8'h00;
		end
		else
		begin
			o_mem_ack <= 1'b0;
			case (rd_state_q)
				RD_IDLE:
					if (i_mem_rd && in_array(i_mem_addr) && read_en_q &&
						!latch_q)
					begin
						if (i_mem_word && mem_ofs[0])
						begin
							rd_hi_q    <= mem_q[mem_ofs];
							rd_next_q  <= mem_ofs + 10'h001;
							rd_state_q <= RD_SECOND;
						end
						else
						begin
							o_mem_ack   <= 1'b1;
							o_mem_rdata <= i_mem_word ?
								{mem_q[mem_ofs], mem_q[mem_ofs | 10'h001]}
								: {8'h00, mem_q[mem_ofs]};
						end
					end
					else if (i_mem_wr && in_array(i_mem_addr))
						o_mem_ack <= 1'b1;
				RD_SECOND:
				begin
					o_mem_ack   <= 1'b1;
					o_mem_rdata <= {rd_hi_q, (rd_next_q < `EE_ARR_END) ?
						mem_q[rd_next_q] : `EE_ERASED};
					rd_state_q  <= RD_IDLE;
				end
				default:
					rd_state_q <= RD_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Pump and clock outputs
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			o_pump_voltage_on <= 1'b0;
			o_rc_osc_run      <= 1'b0;
			o_module_clk_en   <= 1'b1;
		end
		else
		begin
			o_pump_voltage_on <= run;
			o_rc_osc_run      <= psel_q && !i_stop_mode && clk_en;
			o_module_clk_en   <= clk_en;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	sequence s_rd_ok;
		rd_state_q == RD_IDLE && i_mem_rd && in_array(i_mem_addr) &&
			read_en_q && !latch_q;
	endsequence

	a_aligned_read_one: assert property (
		s_rd_ok ##0 !(i_mem_word && mem_ofs[0]) |=> o_mem_ack)
		else $error("aligned read not acked in one cycle");
	a_misaligned_read_two: assert property (
		s_rd_ok ##0 (i_mem_word && mem_ofs[0]) |=> !o_mem_ack ##1 o_mem_ack)
		else $error("misaligned read not acked in two cycles");
	a_latch_blocks_read: assert property (
		rd_state_q == RD_IDLE && latch_q && i_mem_rd && !i_mem_wr
			|=> !o_mem_ack)
		else $error("array answered while latched");
	a_read_enable_gate: assert property (
		rd_state_q == RD_IDLE && !read_en_q && i_mem_rd && !i_mem_wr
			|=> !o_mem_ack)
		else $error("array answered while read disabled");
	a_pgm_needs_latch: assert property (
		$rose(pgm_q) |-> $past(latch_q))
		else $error("voltage enable set without latch");
	a_lock_freezes_bits: assert property (
		lock_q |=> $stable(bprot_q) && $stable(bulk_erase_protection_q))
		else $error("protect bits changed while locked");
	a_lock_write_once: assert property (
		i_special_mode_flag && lock_written_q |=> $stable(lock_q))
		else $error("lock changed after first write");
	a_stop_drops_voltage: assert property (
		i_stop_mode |=> !o_pump_voltage_on ##0 (pgm_q || !$past(pgm_q)))
		else $error("voltage on in stop");
	a_wait_clock_stop: assert property (
		i_wait_mode && wcs_q |=> !o_module_clk_en && !o_rc_osc_run)
		else $error("module clocked in wait with stop bit");

endmodule // eeprom_array_control

// *** cpu_bus_model.sv ***
// Behavioural CPU memory bus master facing the array.
`timescale 1ns/1ps

module cpu_bus_model
(
	input  wire logic        i_core_clk,
	input  wire logic        i_ack,
	input  wire logic [15:0] i_rdata,
	output logic [15:0]      o_addr = 16'h0000,
	output logic             o_rd = 1'b0,
	output logic             o_wr = 1'b0,
	output logic             o_word = 1'b0,
	output logic [15:0]      o_wdata = 16'h0000
);
	// One request a call, then five edges for the answer. Address and
	// data are inverted once taken, so a late sample cannot match by luck.
	task automatic access(input logic w, input logic wd,
		input logic [15:0] a, input logic [15:0] d,
		output int lat, output logic [15:0] q);
		int n;
		lat = 0;
		q = 16'h0000;
		@(posedge i_core_clk);
		o_addr <= a;
		o_wdata <= d;
		o_word <= wd;
		o_rd <= !w;
		o_wr <= w;
		for (n = 1; n <= 5; n++)
		begin
			@(posedge i_core_clk);
			o_rd <= 1'b0;
			o_wr <= 1'b0;
			o_addr <= ~a;
			o_wdata <= ~d;
			if (i_ack === 1'b1 && lat == 0)
			begin
				lat = n;
				q = i_rdata;
			end
		end
	endtask
endmodule // cpu_bus_model

// *** eeprom_array_control_tb_top.sv ***
// Bench for the array control block over both buses.
`timescale 1ns/1ps
`include "eeprom_map.svh"

module eeprom_array_control_tb_top;
	logic        clk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0;
	logic        br = 1'b0, arv = 1'b0, rr = 1'b0, smode = 1'b1;
	logic        wmode = 1'b0, stp = 1'b0;
	logic [15:0] awa = 16'h0000, ara = 16'h0000, ma, mwdat, mq;
	logic [31:0] wd = 32'h00000000, rdat;
	logic        awr, wrd, bv, arr, rv, ack, vlt, rc, cke, mrd, mwr, mw;
	logic [1:0]  bresp, rresp;
	int          err_total = 0, total_checks = 0;

	eeprom_array_control #(.SYS_DIV(2), .RC_DIV(3), .TICKS(8)) u_dut (
		.i_core_clk(clk), .i_srst(srst), .i_awaddr(awa),
		.i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
		.i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wrd),
		.o_bresp(bresp), .o_bvalid(bv), .i_bready(br),
		.i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
		.o_rdata(rdat), .o_rresp(rresp), .o_rvalid(rv),
		.i_rready(rr), .i_mem_addr(ma), .i_mem_rd(mrd),
		.i_mem_wr(mwr), .i_mem_word(mw), .i_mem_wdata(mwdat),
		.o_mem_ack(ack), .o_mem_rdata(mq),
		.i_special_mode_flag(smode), .i_wait_mode(wmode),
		.i_stop_mode(stp), .o_pump_voltage_on(vlt),
		.o_rc_osc_run(rc), .o_module_clk_en(cke));

	cpu_bus_model u_cpu (.i_core_clk(clk), .i_ack(ack), .i_rdata(mq),
		.o_addr(ma), .o_rd(mrd), .o_wr(mwr), .o_word(mw),
		.o_wdata(mwdat));

	initial
	begin
		forever #2.5 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic fail(input string m);
		err_total++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask

	task automatic timeout();
		fail("handshake wait ran out");
		summarize();
	endtask

	task automatic chkv(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e)
			fail($sformatf("value %h expected %h", g, e));
	endtask

	task automatic chkb(input logic g, input logic e);
		total_checks++;
		if (g !== e)
			fail($sformatf("flag %b expected %b", g, e));
	endtask

	task automatic axw(input logic [15:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		awa <= a;
		wd <= {24'h000000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk);
			if (awr === 1'b1)
				awv <= 1'b0;
			if (wrd === 1'b1)
				wv <= 1'b0;
			if (bv === 1'b1)
				break;
		end
		br <= 1'b0;
		if (n == 40)
			timeout();
		chkv(16'(bresp), 16'(`EE_RESP_OKAY));
	endtask

	task automatic axr(input logic [15:0] a, output logic [7:0] q,
		input logic [1:0] r);
		int n;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk);
			if (arr === 1'b1)
				arv <= 1'b0;
			if (rv === 1'b1)
				break;
		end
		rr <= 1'b0;
		if (n == 40)
			timeout();
		q = rdat[7:0];
		chkv(16'(rresp), 16'(r));
	endtask

	task automatic rchk(input logic [15:0] a, input logic [7:0] e,
		input logic [1:0] r = `EE_RESP_OKAY);
		logic [7:0] q;
		axr(a, q, r);
		chkv({8'h00, q}, {8'h00, e});
	endtask

	// For reads d is the expected data; a latency of 0 means no answer.
	task automatic mchk(input logic w, input logic w16,
		input logic [15:0] a, input logic [15:0] d, input int el);
		int lat;
		logic [15:0] q;
		u_cpu.access(w, w16, a, d, lat, q);
		chkv(16'(lat), 16'(el));
		if (!w && el != 0)
			chkv(q, d);
	endtask

	task automatic prog(input logic [7:0] c, input logic w16,
		input logic [15:0] a, input logic [15:0] d, input logic lp);
		int n;
		logic [7:0] q;
		axw(`EE_OFS_PROG, c | 8'h02);
		mchk(1'b1, w16, a, d, 2);
		axw(`EE_OFS_PROG, c | 8'h03);
		@(posedge clk);
		chkb(vlt, 1'b1);
		if (lp)
		begin
			chkb(rc, 1'b1);
			wmode <= 1'b1;
			repeat (3) @(posedge clk);
			chkb(cke, 1'b1);
			chkb(vlt, 1'b1);
			wmode <= 1'b0;
			stp <= 1'b1;
			repeat (3) @(posedge clk);
			chkb(vlt, 1'b0);
			chkb(rc, 1'b0);
			stp <= 1'b0;
			rchk(`EE_OFS_PROG, c | 8'h03);
			chkb(vlt, 1'b1);
		end
		for (n = 0; n < 60; n++)
		begin
			axr(`EE_OFS_INIT, q, `EE_RESP_OKAY);
			if (n > 1 && q[`EE_INIT_DONE] === 1'b1)
				break;
		end
		if (n == 60)
			timeout();
		axw(`EE_OFS_PROG, 8'h00);
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		rchk(`EE_OFS_MCR, 8'hFC);
		rchk(`EE_OFS_PROG, `EE_PROG_RESET);
		rchk(`EE_OFS_INIT, 8'h01);
		rchk(16'h0200, 8'h00, `EE_RESP_SLVERR);
		wmode <= 1'b1;
		repeat (3) @(posedge clk);
		chkb(cke, 1'b0);
		wmode <= 1'b0;
		$display("test reset finished");
		mchk(1'b0, 1'b0, 16'h0D00, 16'h00FF, 2);
		mchk(1'b0, 1'b1, 16'h0FFE, 16'hFFFF, 2);
		mchk(1'b0, 1'b1, 16'h0D01, 16'hFFFF, 3);
		mchk(1'b0, 1'b0, 16'h0CFF, 16'h0000, 0);
		$display("test reads finished");
		axw(`EE_OFS_BPROT, 8'h00);
		axw(`EE_OFS_PROG, 8'h03);
		rchk(`EE_OFS_PROG, 8'h02);
		mchk(1'b0, 1'b0, 16'h0D00, 16'h0000, 0);
		axw(`EE_OFS_PROG, 8'h00);
		prog(8'h00, 1'b1, 16'h0D10, 16'h1234, 1'b0);
		mchk(1'b0, 1'b1, 16'h0D10, 16'h1234, 2);
		prog(8'h00, 1'b1, 16'h0D21, 16'hABCD, 1'b0);
		mchk(1'b0, 1'b1, 16'h0D20, 16'hFFCD, 2);
		prog(8'h14, 1'b0, 16'h0D10, 16'h0000, 1'b0);
		mchk(1'b0, 1'b1, 16'h0D10, 16'hFF34, 2);
		prog(8'h0C, 1'b0, 16'h0D20, 16'h0000, 1'b0);
		mchk(1'b0, 1'b1, 16'h0D20, 16'hFFFF, 2);
		mchk(1'b0, 1'b1, 16'h0D10, 16'hFF34, 2);
		prog(8'h04, 1'b0, 16'h0D00, 16'h0000, 1'b0);
		mchk(1'b0, 1'b1, 16'h0D10, 16'hFFFF, 2);
		axw(`EE_OFS_BPROT, 8'h01);
		prog(8'h00, 1'b1, 16'h0FC0, 16'h5555, 1'b0);
		mchk(1'b0, 1'b1, 16'h0FC0, 16'hFFFF, 2);
		$display("test program finished");
		axw(`EE_OFS_MCR, 8'h03);
		rchk(`EE_OFS_MCR, 8'hFB);
		axw(`EE_OFS_MCR, 8'h01);
		rchk(`EE_OFS_MCR, 8'hFB);
		axw(`EE_OFS_BPROT, 8'h00);
		rchk(`EE_OFS_BPROT, 8'h01);
		prog(8'h00, 1'b1, 16'h0F40, 16'hA5A5, 1'b1);
		mchk(1'b0, 1'b1, 16'h0F40, 16'hA5A5, 2);
		$display("test lock and power finished");
		smode <= 1'b0;
		axw(`EE_OFS_MCR, 8'h00);
		rchk(`EE_OFS_MCR, 8'hF8);
		axw(`EE_OFS_BPROT, 8'h00);
		rchk(`EE_OFS_BPROT, 8'h00);
		axw(`EE_OFS_INIT, 8'h00);
		mchk(1'b0, 1'b1, 16'h0F40, 16'h0000, 0);
		prog(8'h00, 1'b1, 16'h0E00, 16'h7777, 1'b0);
		axw(`EE_OFS_INIT, 8'h01);
		mchk(1'b0, 1'b1, 16'h0E00, 16'h7777, 2);
		prog(8'h00, 1'b1, 16'h0D20, 16'h1357, 1'b0);
		axw(`EE_OFS_TEST, 8'h02);
		rchk(`EE_OFS_TEST, 8'h02);
		prog(8'h04, 1'b0, 16'h0D00, 16'h0000, 1'b0);
		mchk(1'b0, 1'b1, 16'h0D20, 16'hFFFF, 2);
		mchk(1'b0, 1'b1, 16'h0E00, 16'h7777, 2);
		mchk(1'b0, 1'b1, 16'h0F40, 16'hA5A5, 2);
		axw(`EE_OFS_TEST, 8'h00);
		$display("test special finished");
		summarize();
	end
endmodule // eeprom_array_control_tb_top
